//--- logic/ipr_pkg.sv
// constants for the interrupt priority register bank
// assumes an axi4-lite master and one 125 MHz clock domain
package ipr_pkg;
  // ****************************************************************
  // register byte offsets (word indices 0..6 times four)
  // ****************************************************************
  localparam logic [7:0] CAPTURE_DMA_OFS     = 8'h00;
  localparam logic [7:0] SECOND_I2C_OFS      = 8'h04;
  localparam logic [7:0] EXTERNAL_LINE_OFS   = 8'h08;
  localparam logic [7:0] ENCODER_PWM_OFS     = 8'h0C;
  localparam logic [7:0] SERIAL_ERROR_OFS    = 8'h10;
  localparam logic [7:0] CAN_TRANSMIT_OFS    = 8'h14;
  localparam logic [7:0] ENCODER2_PWM2_OFS   = 8'h18;
  // ****************************************************************
  // field positions (low bit of each 3-bit field)
  // ****************************************************************
  localparam int FLD_HI  = 12;
  localparam int FLD_MID = 8;
  localparam int FLD_LO  = 4;
  localparam int FLD_BOT = 0;
  // ****************************************************************
  // values
  // ****************************************************************
  localparam logic [2:0] LEVEL_RESET = 3'h4;
  localparam logic [2:0] LEVEL_OFF   = 3'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // number of sources in the effective-level vector
  localparam int SRC_COUNT = 14;
endpackage

//--- logic/ipr_regs.sv
// interrupt priority register bank with an axi4-lite slave port
// assumes the arbiter outside reads the effective levels as plain levels
// Contract
// - field code is the level directly: 111 highest, 001 lowest
// - field 000 disables its source, never presented for service
// - unimplemented bits read zero and ignore writes
// - second i2c: master level bits 10-8, slave level bits 6-4
// - second decoder level bits 14-12, secondary pwm match bits 6-4
// - without can controller, can transmit source is always disabled
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module ipr_regs #(
  parameter bit HAS_CAN = 1'b1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output      logic [41:0] src_level,
  output      logic [13:0] src_enabled
);
  // ****************************************************************
  // field storage
  // ****************************************************************
  logic [2:0] capture4_level_ff, capture3_level_ff, dma_ch3_done_level_ff;
  logic [2:0] i2c_b_master_level_ff, i2c_b_slave_level_ff;
  logic [2:0] ext_line4_level_ff, ext_line3_level_ff;
  logic [2:0] decoder_a_level_ff, pwm_special_match_level_ff;
  logic [2:0] serial_b_error_level_ff, serial_a_error_level_ff;
  logic [2:0] can_tx_request_level_ff;
  logic [2:0] decoder_b_level_ff, pwm_secondary_match_level_ff;

  logic        aw_held_ff, w_held_ff;
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        bvalid_ff, rvalid_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic        do_write;

  // true when the byte offset names one of the seven registers
  function automatic logic ipr_mapped(input logic [7:0] a);
    if (a == ipr_pkg::CAPTURE_DMA_OFS) return 1'b1;
    else if (a == ipr_pkg::SECOND_I2C_OFS) return 1'b1;
    else if (a == ipr_pkg::EXTERNAL_LINE_OFS) return 1'b1;
    else if (a == ipr_pkg::ENCODER_PWM_OFS) return 1'b1;
    else if (a == ipr_pkg::SERIAL_ERROR_OFS) return 1'b1;
    else if (a == ipr_pkg::CAN_TRANSMIT_OFS) return 1'b1;
    else if (a == ipr_pkg::ENCODER2_PWM2_OFS) return 1'b1;
    else return 1'b0;
  endfunction

  // ****************************************************************
  // write channel
  // ****************************************************************
  // address and data accepted in either order, held until response
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign do_write      = aw_held_ff && w_held_ff && !bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // write response, slverr for unmapped offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= ipr_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= ipr_mapped(aw_addr_ff) ? ipr_pkg::RESP_OKAY
                                          : ipr_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // ****************************************************************
  // field updates
  // ****************************************************************
  // only lanes 0 and 1 hold fields; upper lanes are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture4_level_ff            <= ipr_pkg::LEVEL_RESET;
      capture3_level_ff            <= ipr_pkg::LEVEL_RESET;
      dma_ch3_done_level_ff        <= ipr_pkg::LEVEL_RESET;
      i2c_b_master_level_ff        <= ipr_pkg::LEVEL_RESET;
      i2c_b_slave_level_ff         <= ipr_pkg::LEVEL_RESET;
      ext_line4_level_ff           <= ipr_pkg::LEVEL_RESET;
      ext_line3_level_ff           <= ipr_pkg::LEVEL_RESET;
      decoder_a_level_ff           <= ipr_pkg::LEVEL_RESET;
      pwm_special_match_level_ff   <= ipr_pkg::LEVEL_RESET;
      serial_b_error_level_ff      <= ipr_pkg::LEVEL_RESET;
      serial_a_error_level_ff      <= ipr_pkg::LEVEL_RESET;
      can_tx_request_level_ff      <= ipr_pkg::LEVEL_RESET;
      decoder_b_level_ff           <= ipr_pkg::LEVEL_RESET;
      pwm_secondary_match_level_ff <= ipr_pkg::LEVEL_RESET;
    end else if (do_write) begin
      if (aw_addr_ff == ipr_pkg::CAPTURE_DMA_OFS) begin
        if (w_strb_ff[1])
          capture4_level_ff <= w_data_ff[ipr_pkg::FLD_MID +: 3];
        if (w_strb_ff[0]) begin
          capture3_level_ff     <= w_data_ff[ipr_pkg::FLD_LO +: 3];
          dma_ch3_done_level_ff <= w_data_ff[ipr_pkg::FLD_BOT +: 3];
        end
      end else if (aw_addr_ff == ipr_pkg::SECOND_I2C_OFS) begin
        if (w_strb_ff[1])
          i2c_b_master_level_ff <= w_data_ff[ipr_pkg::FLD_MID +: 3];
        if (w_strb_ff[0])
          i2c_b_slave_level_ff <= w_data_ff[ipr_pkg::FLD_LO +: 3];
      end else if (aw_addr_ff == ipr_pkg::EXTERNAL_LINE_OFS) begin
        if (w_strb_ff[1])
          ext_line4_level_ff <= w_data_ff[ipr_pkg::FLD_MID +: 3];
        if (w_strb_ff[0])
          ext_line3_level_ff <= w_data_ff[ipr_pkg::FLD_LO +: 3];
      end else if (aw_addr_ff == ipr_pkg::ENCODER_PWM_OFS) begin
        if (w_strb_ff[1])
          decoder_a_level_ff <= w_data_ff[ipr_pkg::FLD_MID +: 3];
        if (w_strb_ff[0])
          pwm_special_match_level_ff <= w_data_ff[ipr_pkg::FLD_LO +: 3];
      end else if (aw_addr_ff == ipr_pkg::SERIAL_ERROR_OFS) begin
        if (w_strb_ff[1])
          serial_b_error_level_ff <= w_data_ff[ipr_pkg::FLD_MID +: 3];
        if (w_strb_ff[0])
          serial_a_error_level_ff <= w_data_ff[ipr_pkg::FLD_LO +: 3];
      end else if (aw_addr_ff == ipr_pkg::CAN_TRANSMIT_OFS) begin
        if (w_strb_ff[1])
          can_tx_request_level_ff <= w_data_ff[ipr_pkg::FLD_MID +: 3];
      end else if (aw_addr_ff == ipr_pkg::ENCODER2_PWM2_OFS) begin
        if (w_strb_ff[1])
          decoder_b_level_ff <= w_data_ff[ipr_pkg::FLD_HI +: 3];
        if (w_strb_ff[0])
          pwm_secondary_match_level_ff <= w_data_ff[ipr_pkg::FLD_LO +: 3];
      end
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  // read image: unimplemented positions are constant zero
  function automatic logic [31:0] ipr_image(input logic [7:0] a,
                                            input logic [41:0] l);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == ipr_pkg::CAPTURE_DMA_OFS) begin
      v[ipr_pkg::FLD_MID +: 3] = l[2:0];
      v[ipr_pkg::FLD_LO +: 3]  = l[5:3];
      v[ipr_pkg::FLD_BOT +: 3] = l[8:6];
    end else if (a == ipr_pkg::SECOND_I2C_OFS) begin
      v[ipr_pkg::FLD_MID +: 3] = l[11:9];
      v[ipr_pkg::FLD_LO +: 3]  = l[14:12];
    end else if (a == ipr_pkg::EXTERNAL_LINE_OFS) begin
      v[ipr_pkg::FLD_MID +: 3] = l[17:15];
      v[ipr_pkg::FLD_LO +: 3]  = l[20:18];
    end else if (a == ipr_pkg::ENCODER_PWM_OFS) begin
      v[ipr_pkg::FLD_MID +: 3] = l[23:21];
      v[ipr_pkg::FLD_LO +: 3]  = l[26:24];
    end else if (a == ipr_pkg::SERIAL_ERROR_OFS) begin
      v[ipr_pkg::FLD_MID +: 3] = l[29:27];
      v[ipr_pkg::FLD_LO +: 3]  = l[32:30];
    end else if (a == ipr_pkg::CAN_TRANSMIT_OFS) begin
      v[ipr_pkg::FLD_MID +: 3] = l[35:33];
    end else if (a == ipr_pkg::ENCODER2_PWM2_OFS) begin
      v[ipr_pkg::FLD_HI +: 3] = l[38:36];
      v[ipr_pkg::FLD_LO +: 3] = l[41:39];
    end
    return v;
  endfunction

  // stored fields, raw, in source order
  logic [41:0] raw_level;
  assign raw_level = {pwm_secondary_match_level_ff, decoder_b_level_ff,
                      can_tx_request_level_ff, serial_a_error_level_ff,
                      serial_b_error_level_ff, pwm_special_match_level_ff,
                      decoder_a_level_ff, ext_line3_level_ff,
                      ext_line4_level_ff, i2c_b_slave_level_ff,
                      i2c_b_master_level_ff, dma_ch3_done_level_ff,
                      capture3_level_ff, capture4_level_ff};

  assign s_axi_arready = !rvalid_ff;

  // one read at a time, answered the cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= ipr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= ipr_image(s_axi_araddr, raw_level);
      rresp_ff  <= ipr_mapped(s_axi_araddr) ? ipr_pkg::RESP_OKAY
                                            : ipr_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // ****************************************************************
  // effective levels for the arbiter
  // ****************************************************************
  // code is the level itself; 000 masks the source
  always_comb begin
    src_level = raw_level;
    if (!HAS_CAN)
      src_level[35:33] = ipr_pkg::LEVEL_OFF;
    for (int i = 0; i < ipr_pkg::SRC_COUNT; i++)
      src_enabled[i] = (src_level[3*i +: 3] != ipr_pkg::LEVEL_OFF);
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence ipr_wr_done;
    do_write;
  endsequence

  AST_LEVEL_ZERO_OFF: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (src_level[2:0] == 3'h0) |-> !src_enabled[0])
    else $error("disabled source enabled");
  AST_LEVEL_PASS: assert property (
    @(posedge aclk) disable iff (!aresetn)
    src_level[5:3] == capture3_level_ff)
    else $error("level not passed through");
  AST_CAN_OFF: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !HAS_CAN |-> !src_enabled[11])
    else $error("can source enabled without can");
  AST_READ_ZERO: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> (s_axi_rdata[31:15] == 17'h0_0000)
    && !s_axi_rdata[11] && !s_axi_rdata[7] && !s_axi_rdata[3])
    else $error("unimplemented bits read nonzero");
  // unmapped offsets answer with an error and an all-zero word
  AST_UNMAPPED_READ: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && !ipr_mapped(s_axi_araddr))
    |=> (s_axi_rresp == ipr_pkg::RESP_SLVERR)
        && (s_axi_rdata == 32'h0000_0000))
    else $error("unmapped read not refused");
  AST_I2C_WRITE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ipr_wr_done and aw_addr_ff == ipr_pkg::SECOND_I2C_OFS
     and w_strb_ff[1]) |=> i2c_b_master_level_ff == $past(w_data_ff[10:8]))
    else $error("i2c master field wrong");
  AST_I2C_SLAVE_WRITE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ipr_wr_done and aw_addr_ff == ipr_pkg::SECOND_I2C_OFS
     and w_strb_ff[0]) |=> i2c_b_slave_level_ff == $past(w_data_ff[6:4]))
    else $error("i2c slave field wrong");
  AST_DEC_WRITE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ipr_wr_done and aw_addr_ff == ipr_pkg::ENCODER2_PWM2_OFS
     and w_strb_ff[1]) |=> decoder_b_level_ff == $past(w_data_ff[14:12]))
    else $error("decoder b field wrong");
  AST_PWM2_WRITE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ipr_wr_done and aw_addr_ff == ipr_pkg::ENCODER2_PWM2_OFS
     and w_strb_ff[0])
    |=> pwm_secondary_match_level_ff == $past(w_data_ff[6:4]))
    else $error("secondary pwm field wrong");
  // no disable here: this one watches the reset itself
  AST_RESET_LEVEL: assert property (
    @(posedge aclk)
    !aresetn |=> can_tx_request_level_ff == ipr_pkg::LEVEL_RESET)
    else $error("reset level not four");
  AST_B_AFTER_WRITE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ipr_wr_done |=> s_axi_bvalid)
    else $error("write response missing");
endmodule // ipr_regs

//--- verification/interrupt_priority_regs_tb.sv
// self-checking bench for the interrupt priority register bank
// assumes ipr_pkg and ipr_regs are compiled first; one 125 MHz clock
`timescale 1ns/100ps
module interrupt_priority_regs_tb;
  // ****************************************************************
  // signals and shadow state
  // ****************************************************************
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [41:0] lvl;
  logic [13:0] ena;
  logic [41:0] lvl_nc;
  logic [13:0] ena_nc;
  logic [15:0] sh [7];
  logic [31:0] d;
  logic [3:0]  s;
  logic [1:0]  r;
  int          fail_count;
  int          total_checks;
  int          seed;
  int          i;
  // implemented bits of each word, offsets 0x00..0x18
  localparam logic [15:0] MASK [7] = '{16'h0777, 16'h0770, 16'h0770,
    16'h0770, 16'h0770, 16'h0700, 16'h7070};
  // second copy without the can controller, sharing every input
  ipr_regs #(.HAS_CAN(1'b1)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .src_level(lvl),
    .src_enabled(ena));
  ipr_regs #(.HAS_CAN(1'b0)) uut_nocan (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
    .src_level(lvl_nc), .src_enabled(ena_nc));
  always #4 aclk = ~aclk;
  // ****************************************************************
  // expectation functions and bus tasks
  // ****************************************************************
  // effective levels in output order, can field forced off without can
  function automatic logic [41:0] exp_lvl(input bit nocan);
    exp_lvl = {sh[6][6:4], sh[6][14:12], nocan ? 3'h0 : sh[5][10:8],
      sh[4][6:4], sh[4][10:8], sh[3][6:4], sh[3][10:8], sh[2][6:4],
      sh[2][10:8], sh[1][6:4], sh[1][10:8], sh[0][2:0], sh[0][6:4],
      sh[0][10:8]};
  endfunction
  function automatic logic [41:0] exp_en(input logic [41:0] l);
    exp_en = '0;
    for (int k = 0; k < 14; k++) exp_en[k] = |l[3*k+:3];
  endfunction
  task automatic cmp(input string nm, input logic [41:0] e,
                     input logic [41:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dt,
                    input logic [3:0] st, output logic [1:0] rs);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dt;
    wstrb <= st;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dt,
                    output logic [1:0] rs);
    bit ad;
    ad = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (!ad && arready) begin
        ad = 1;
        arvalid <= 1'b0;
      end
      if (rvalid) break;
    end
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // levels are registered, so let two edges pass before looking
  task automatic check_out();
    repeat (2) @(posedge aclk);
    cmp("src_level", exp_lvl(0), lvl);
    cmp("src_enabled", exp_en(exp_lvl(0)), 42'(ena));
    cmp("nocan_level", exp_lvl(1), lvl_nc);
    cmp("nocan_enabled", exp_en(exp_lvl(1)), 42'(ena_nc));
  endtask
  task automatic chk_reg(input int k);
    rd(8'(4*k), d, r);
    cmp("rresp", 42'(ipr_pkg::RESP_OKAY), 42'(r));
    cmp("rdata", 42'({16'h0, sh[k]}), 42'(d));
  endtask
  task automatic reset_check();
    for (int k = 0; k < 7; k++) begin
      sh[k] = MASK[k] & 16'h4444;
      chk_reg(k);
    end
    check_out();
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************************************
  // stimulus
  // ****************************************************************
  // watchdog, the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    results();
  end
  initial begin
    {aclk, aresetn, awaddr, awvalid, wdata, wstrb, wvalid} = '0;
    {bready, araddr, arvalid, rready} = '0;
    fail_count = 0;
    total_checks = 0;
    seed = 30467;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    reset_check();
    // every code into every field, upper strobes set but ignored
    for (int c = 0; c < 8; c++) begin
      for (int k = 0; k < 7; k++) begin
        wr(8'(4*k), {16'hFFFF, 16'(16'h1111 * c)}, 4'hF, r);
        sh[k] = MASK[k] & 16'(16'h1111 * c);
        cmp("bresp", 42'(ipr_pkg::RESP_OKAY), 42'(r));
      end
      check_out();
    end
    // random words and byte strobes with readback
    repeat (40) begin
      i = $unsigned($random(seed)) % 7;
      d = $random(seed);
      s = 4'($random(seed));
      wr(8'(4*i), d, s, r);
      cmp("bresp_random", 42'(ipr_pkg::RESP_OKAY), 42'(r));
      for (int b = 0; b < 2; b++)
        if (s[b]) sh[i][8*b+:8] = d[8*b+:8] & MASK[i][8*b+:8];
      chk_reg(i);
      check_out();
    end
    // unmapped places refuse and leave all fields alone
    for (int k = 0; k < 2; k++) begin
      wr(k ? 8'hFC : 8'h1C, 32'hFFFFFFFF, 4'hF, r);
      cmp("bresp_unmapped", 42'(ipr_pkg::RESP_SLVERR), 42'(r));
      rd(k ? 8'hFC : 8'h1C, d, r);
      cmp("rresp_unmapped", 42'(ipr_pkg::RESP_SLVERR), 42'(r));
      cmp("rdata_unmapped", 42'h0, 42'(d));
      check_out();
    end
    // second reset in mid-run restores level 4 everywhere
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    reset_check();
    results();
  end
endmodule // interrupt_priority_regs_tb
